// >>> logic/p9m_pin_mux.sv
// Pin-function multiplexer for sixteen port-9 pins and four chip-select pins.
// Assumes all inputs synchronous to i_ref_clk; pad logic resolves out/oe.
`timescale 1ns/1ps
`default_nettype none
`include "p9m_cfg.svh"

module p9m_pin_mux
  import p9m_pkg::*;
(
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  input  wire logic [`P9M_PORT_W-1:0]   i_function_select_bit,
  input  wire logic [`P9M_PORT_W-1:0]   i_function_extension_bit,
  input  wire logic [`P9M_PORT_W-1:0]   i_function_choice_bit,
  input  wire logic [`P9M_PORT_W-1:0]   i_open_drain_bit,
  input  wire logic [`P9M_PORT_W-1:0]   i_port_direction_bit,
  input  wire logic [`P9M_PORT_W-1:0]   i_port_latch,
  input  wire logic [`P9M_PORT_W-1:0]   i_pin_in,
  input  wire logic [`P9M_CS_W-1:0]     i_cs_function_select_bit,
  input  wire logic [`P9M_CS_W-1:0]     i_cs_port_direction_bit,
  input  wire logic [`P9M_CS_W-1:0]     i_cs_port_latch,
  input  wire logic [`P9M_CS_W-1:0]     i_cs_pin_in,
  input  wire logic [`P9M_CS_W-1:0]     i_chip_select_out,
  input  wire logic [`P9M_PORT_W-1:0]   i_addr,
  input  wire logic                     i_uart1_transmit,
  input  wire logic                     i_i2c2_serial_data_out,
  input  wire logic                     i_i2c2_serial_clock_out,
  input  wire logic                     i_timer4_ch1_out,
  input  wire logic                     i_timer4_ch0_out,
  input  wire logic                     i_timer3_ch1_out,
  input  wire logic                     i_timer3_ch0_out,
  input  wire logic                     i_timer2_ch1_out,
  input  wire logic                     i_timer2_ch0_out,
  input  wire logic                     i_timer5_ch1_out,
  input  wire logic                     i_timer5_ch0_out,
  input  wire logic                     i_serial1_data_out,
  input  wire logic                     i_serial1_clock_out,
  input  wire logic                     i_serial1_clock_oe,
  input  wire logic                     i_serial3_data_out,
  input  wire logic                     i_serial3_clock_out,
  input  wire logic                     i_serial3_clock_oe,
  output logic [`P9M_PORT_W-1:0]        o_pin_out,
  output logic [`P9M_PORT_W-1:0]        o_pin_oe,
  output logic [`P9M_PORT_W-1:0]        o_port_read,
  output logic [`P9M_CS_W-1:0]          o_cs_pin_out,
  output logic [`P9M_CS_W-1:0]          o_cs_pin_oe,
  output logic [`P9M_CS_W-1:0]          o_cs_port_read,
  output logic                          o_key_return_in_6,
  output logic                          o_key_return_in_7,
  output logic                          o_uart1_receive,
  output logic                          o_i2c2_serial_data_in,
  output logic                          o_i2c2_serial_clock_in,
  output logic                          o_timer4_ch1_capture_in,
  output logic                          o_timer4_ch0_capture_in,
  output logic                          o_timer3_ch1_capture_in,
  output logic                          o_timer3_ch0_capture_in,
  output logic                          o_timer2_ch1_capture_in,
  output logic                          o_timer2_ch0_capture_in,
  output logic                          o_serial1_data_in,
  output logic                          o_serial1_clock_in,
  output logic                          o_serial3_data_in,
  output logic                          o_serial3_clock_in,
  output logic                          o_ext_irq_in_4,
  output logic                          o_ext_irq_in_5,
  output logic                          o_ext_irq_in_6,
  output logic                          o_timer5_ch1_capture_in,
  output logic                          o_timer5_ch0_capture_in
);

  // -----------------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------------
  function automatic p9m_sel_t p9m_dec(input logic ext, input logic ch);
    p9m_sel_t s;
    case ({ext, ch})
      2'h0:    s = P9M_SEL_00;
      2'h1:    s = P9M_SEL_01;
      2'h2:    s = P9M_SEL_10;
      default: s = P9M_SEL_11;
    endcase
    return s;
  endfunction

  logic [`P9M_PORT_W-1:0] pin_out_nxt;
  logic [`P9M_PORT_W-1:0] pin_oe_nxt;
  logic [`P9M_FI_W-1:0]   fi_nxt;
  logic [`P9M_FI_W-1:0]   fi_r;
  logic [3:0]             tmr_out;
  logic [5:0]             ch_out;
  logic [5:0]             ch_oe;
  p9m_sel_t               sel [`P9M_PORT_W];

  assign tmr_out = {i_timer3_ch0_out, i_timer3_ch1_out,
                    i_timer4_ch0_out, i_timer4_ch1_out};
  assign ch_out  = {1'b0, i_serial3_clock_out, i_serial3_data_out,
                    1'b0, i_serial1_clock_out, i_serial1_data_out};
  assign ch_oe   = {1'b0, i_serial3_clock_oe, 1'b1,
                    1'b0, i_serial1_clock_oe, 1'b1};

  // -----------------------------------------------------------------------
  // Pin routing
  // -----------------------------------------------------------------------
  always_comb begin
    pin_out_nxt = `P9M_RST_PORT;
    pin_oe_nxt  = `P9M_RST_PORT;
    fi_nxt      = `P9M_RST_FI;
    for (int i = 0; i < `P9M_PORT_W; i++) begin
      sel[i] = p9m_dec(i_function_extension_bit[i], i_function_choice_bit[i]);
      if (!i_function_select_bit[i]) begin
        // Plain port pin, open drain drives low only
        pin_out_nxt[i] = i_port_latch[i];
        pin_oe_nxt[i]  = !i_port_direction_bit[i] &&
                         !(i_open_drain_bit[i] && i_port_latch[i]);
      end else if ((i >= `P9M_PIN_CH_LO && i <= `P9M_PIN_CH_HI) ?
                   !i_function_choice_bit[i] :
                   sel[i] == P9M_SEL_00) begin
        // Address output, latch and direction ignored
        pin_out_nxt[i] = i_addr[i];
        pin_oe_nxt[i]  = 1'b1;
      end
    end
    // Uart / key return / i2c data pin
    if (i_function_select_bit[`P9M_PIN_UART]) begin
      case (sel[`P9M_PIN_UART])
        P9M_SEL_01: fi_nxt[`P9M_FI_KR6] = i_pin_in[`P9M_PIN_UART];
        P9M_SEL_10: begin
          pin_out_nxt[`P9M_PIN_UART] = i_uart1_transmit;
          pin_oe_nxt[`P9M_PIN_UART]  = 1'b1;
        end
        P9M_SEL_11: begin
          if (i_open_drain_bit[`P9M_PIN_UART]) begin
            pin_out_nxt[`P9M_PIN_UART] = 1'b0;
            pin_oe_nxt[`P9M_PIN_UART]  = !i_i2c2_serial_data_out;
            fi_nxt[`P9M_FI_SDA]        = i_pin_in[`P9M_PIN_UART];
          end
        end
        default: ;
      endcase
    end
    // Key return 7 / uart receive / i2c clock pin
    if (i_function_select_bit[`P9M_PIN_I2C_CLK]) begin
      case (sel[`P9M_PIN_I2C_CLK])
        P9M_SEL_01: fi_nxt[`P9M_FI_KR7] = i_pin_in[`P9M_PIN_I2C_CLK];
        P9M_SEL_10: begin
          // Shared input feeds both users
          fi_nxt[`P9M_FI_URX] = i_pin_in[`P9M_PIN_I2C_CLK];
          fi_nxt[`P9M_FI_KR7] = i_pin_in[`P9M_PIN_I2C_CLK];
        end
        P9M_SEL_11: begin
          if (i_open_drain_bit[`P9M_PIN_I2C_CLK]) begin
            pin_out_nxt[`P9M_PIN_I2C_CLK] = 1'b0;
            pin_oe_nxt[`P9M_PIN_I2C_CLK]  = !i_i2c2_serial_clock_out;
            fi_nxt[`P9M_FI_SCL] = i_pin_in[`P9M_PIN_I2C_CLK];
          end
        end
        default: ;
      endcase
    end
    // Timer 4/3 pins, code 11 left inactive
    for (int i = `P9M_PIN_TMR_LO; i <= `P9M_PIN_TMR_HI; i++) begin
      if (i_function_select_bit[i]) begin
        case (sel[i])
          P9M_SEL_01:
            fi_nxt[`P9M_FI_CAP_LO + i - `P9M_PIN_TMR_LO] = i_pin_in[i];
          P9M_SEL_10: begin
            pin_out_nxt[i] = tmr_out[i - `P9M_PIN_TMR_LO];
            pin_oe_nxt[i]  = 1'b1;
          end
          default: ;
        endcase
      end
    end
    // Timer 2 ch1 pin, code 01 left inactive
    if (i_function_select_bit[`P9M_PIN_T2C1]) begin
      case (sel[`P9M_PIN_T2C1])
        P9M_SEL_10: fi_nxt[`P9M_FI_T2C1] = i_pin_in[`P9M_PIN_T2C1];
        P9M_SEL_11: begin
          pin_out_nxt[`P9M_PIN_T2C1] = i_timer2_ch1_out;
          pin_oe_nxt[`P9M_PIN_T2C1]  = 1'b1;
        end
        default: ;
      endcase
    end
    // Serial 1 input / timer 2 ch0 pin
    if (i_function_select_bit[`P9M_PIN_T2C0]) begin
      case (sel[`P9M_PIN_T2C0])
        P9M_SEL_01: fi_nxt[`P9M_FI_S1DI] = i_pin_in[`P9M_PIN_T2C0];
        P9M_SEL_10: fi_nxt[`P9M_FI_T2C0] = i_pin_in[`P9M_PIN_T2C0];
        P9M_SEL_11: begin
          pin_out_nxt[`P9M_PIN_T2C0] = i_timer2_ch0_out;
          pin_oe_nxt[`P9M_PIN_T2C0]  = 1'b1;
        end
        default: ;
      endcase
    end
    // Choice-only pins, extension bit ignored
    for (int i = `P9M_PIN_CH_LO; i <= `P9M_PIN_CH_HI; i++) begin
      if (i_function_select_bit[i] && i_function_choice_bit[i]) begin
        pin_out_nxt[i] = ch_out[i - `P9M_PIN_CH_LO];
        pin_oe_nxt[i]  = ch_oe[i - `P9M_PIN_CH_LO];
      end
    end
    if (i_function_select_bit[9] && i_function_choice_bit[9])
      fi_nxt[`P9M_FI_S1CK] = i_pin_in[9];
    if (i_function_select_bit[10] && i_function_choice_bit[10])
      fi_nxt[`P9M_FI_S3DI] = i_pin_in[10];
    if (i_function_select_bit[12] && i_function_choice_bit[12])
      fi_nxt[`P9M_FI_S3CK] = i_pin_in[12];
    if (i_function_select_bit[13] && i_function_choice_bit[13])
      fi_nxt[`P9M_FI_IRQ4] = i_pin_in[13];
    // Timer 5 pins
    if (i_function_select_bit[`P9M_PIN_T5C1]) begin
      case (sel[`P9M_PIN_T5C1])
        P9M_SEL_01: fi_nxt[`P9M_FI_IRQ5] = i_pin_in[`P9M_PIN_T5C1];
        P9M_SEL_10: fi_nxt[`P9M_FI_T5C1] = i_pin_in[`P9M_PIN_T5C1];
        P9M_SEL_11: begin
          pin_out_nxt[`P9M_PIN_T5C1] = i_timer5_ch1_out;
          pin_oe_nxt[`P9M_PIN_T5C1]  = 1'b1;
        end
        default: ;
      endcase
    end
    if (i_function_select_bit[`P9M_PIN_T5C0]) begin
      case (sel[`P9M_PIN_T5C0])
        P9M_SEL_01: fi_nxt[`P9M_FI_IRQ6] = i_pin_in[`P9M_PIN_T5C0];
        P9M_SEL_10: fi_nxt[`P9M_FI_T5C0] = i_pin_in[`P9M_PIN_T5C0];
        P9M_SEL_11: begin
          pin_out_nxt[`P9M_PIN_T5C0] = i_timer5_ch0_out;
          pin_oe_nxt[`P9M_PIN_T5C0]  = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Port-9 pad registers
  // -----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_pin_out   <= `P9M_RST_PORT;
      o_pin_oe    <= `P9M_RST_PORT;
      o_port_read <= `P9M_RST_PORT;
    end else begin
      o_pin_out   <= pin_out_nxt;
      o_pin_oe    <= pin_oe_nxt;
      o_port_read <= i_pin_in;
    end
  end

  // -----------------------------------------------------------------------
  // Chip-select pins
  // -----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_cs_pin_out   <= `P9M_RST_CS;
      o_cs_pin_oe    <= `P9M_RST_CS;
      o_cs_port_read <= `P9M_RST_CS;
    end else begin
      for (int i = 0; i < `P9M_CS_W; i++) begin
        if (i_cs_function_select_bit[i]) begin
          o_cs_pin_out[i] <= i_chip_select_out[i];
          o_cs_pin_oe[i]  <= 1'b1;
        end else begin
          o_cs_pin_out[i] <= i_cs_port_latch[i];
          o_cs_pin_oe[i]  <= !i_cs_port_direction_bit[i];
        end
      end
      o_cs_port_read <= i_cs_pin_in;
    end
  end

  // -----------------------------------------------------------------------
  // Peripheral inputs
  // -----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n)
      fi_r <= `P9M_RST_FI;
    else
      fi_r <= fi_nxt;
  end

  assign o_key_return_in_6       = fi_r[`P9M_FI_KR6];
  assign o_key_return_in_7       = fi_r[`P9M_FI_KR7];
  assign o_uart1_receive         = fi_r[`P9M_FI_URX];
  assign o_i2c2_serial_data_in   = fi_r[`P9M_FI_SDA];
  assign o_i2c2_serial_clock_in  = fi_r[`P9M_FI_SCL];
  assign o_timer4_ch1_capture_in = fi_r[`P9M_FI_CAP_LO];
  assign o_timer4_ch0_capture_in = fi_r[`P9M_FI_CAP_LO + 1];
  assign o_timer3_ch1_capture_in = fi_r[`P9M_FI_CAP_LO + 2];
  assign o_timer3_ch0_capture_in = fi_r[`P9M_FI_CAP_LO + 3];
  assign o_timer2_ch1_capture_in = fi_r[`P9M_FI_T2C1];
  assign o_timer2_ch0_capture_in = fi_r[`P9M_FI_T2C0];
  assign o_serial1_data_in       = fi_r[`P9M_FI_S1DI];
  assign o_serial1_clock_in      = fi_r[`P9M_FI_S1CK];
  assign o_serial3_data_in       = fi_r[`P9M_FI_S3DI];
  assign o_serial3_clock_in      = fi_r[`P9M_FI_S3CK];
  assign o_ext_irq_in_4          = fi_r[`P9M_FI_IRQ4];
  assign o_ext_irq_in_5          = fi_r[`P9M_FI_IRQ5];
  assign o_ext_irq_in_6          = fi_r[`P9M_FI_IRQ6];
  assign o_timer5_ch1_capture_in = fi_r[`P9M_FI_T5C1];
  assign o_timer5_ch0_capture_in = fi_r[`P9M_FI_T5C0];

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  a_uart_tx_route: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[0] && i_function_extension_bit[0] &&
     !i_function_choice_bit[0])
    |=> (o_pin_oe[0] && o_pin_out[0] == $past(i_uart1_transmit)))
    else $error("uart transmit not routed to bit 0");

  a_shared_rx_kr7: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[1] && i_function_extension_bit[1] &&
     !i_function_choice_bit[1])
    |=> (o_uart1_receive == $past(i_pin_in[1]) &&
         o_key_return_in_7 == $past(i_pin_in[1]) && !o_pin_oe[1]))
    else $error("shared receive input not routed");

  a_timer_out_pin: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[4] && i_function_extension_bit[4] &&
     !i_function_choice_bit[4])
    |=> (o_pin_oe[4] && o_pin_out[4] == $past(i_timer3_ch1_out)))
    else $error("timer3 ch1 output not on bit 4");

  a_t2c1_undefined: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[6] && !i_function_extension_bit[6] &&
     i_function_choice_bit[6])
    |=> (!o_pin_oe[6] && !o_timer2_ch1_capture_in))
    else $error("bit 6 code 01 must stay inactive");

  a_ser1_din_route: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[7] && !i_function_extension_bit[7] &&
     i_function_choice_bit[7])
    |=> (o_serial1_data_in == $past(i_pin_in[7]) && !o_pin_oe[7]))
    else $error("serial1 data input not routed");

  a_irq4_choice: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[13] && i_function_choice_bit[13])
    |=> (o_ext_irq_in_4 == $past(i_pin_in[13]) && !o_pin_oe[13]))
    else $error("irq 4 input not routed");

  a_t5_capture: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[14] && i_function_extension_bit[14] &&
     !i_function_choice_bit[14])
    |=> (o_timer5_ch1_capture_in == $past(i_pin_in[14]) && !o_pin_oe[14]))
    else $error("timer5 ch1 capture not routed");

  a_choice_addr_out: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[8] && i_function_extension_bit[8] &&
     !i_function_choice_bit[8])
    |=> (o_pin_oe[8] && o_pin_out[8] == $past(i_addr[8])))
    else $error("choice-only pin lost its address output");

  a_t5c0_output: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[15] && i_function_extension_bit[15] &&
     i_function_choice_bit[15])
    |=> (o_pin_oe[15] && o_pin_out[15] == $past(i_timer5_ch0_out)))
    else $error("timer5 ch0 output not on bit 15");

  a_cs_output: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_cs_function_select_bit[2]
    |=> (o_cs_pin_oe[2] && o_cs_pin_out[2] == $past(i_chip_select_out[2])))
    else $error("chip select 2 not driven");

  a_addr_ignores_dir: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[15] && !i_function_extension_bit[15] &&
     !i_function_choice_bit[15] && i_port_direction_bit[15])
    |=> (o_pin_oe[15] && o_pin_out[15] == $past(i_addr[15])))
    else $error("address output disturbed by direction bit");

  a_i2c_needs_od: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_function_select_bit[0] && i_function_extension_bit[0] &&
     i_function_choice_bit[0] && !i_open_drain_bit[0])
    |=> (!o_pin_oe[0] && !o_i2c2_serial_data_in))
    else $error("i2c data active without open drain");

  a_gpio_mode: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_function_select_bit[3] && !i_port_direction_bit[3] &&
     !i_open_drain_bit[3])
    |=> (o_pin_oe[3] && o_pin_out[3] == $past(i_port_latch[3])))
    else $error("port pin not following latch");

endmodule
`default_nettype wire

// >>> logic/p9m_cfg.svh
// Constants for the port-9 / chip-select pin-function multiplexer.
// Assumes inclusion by bare name from the package and the top module.
`ifndef P9M_CFG_SVH
`define P9M_CFG_SVH

// -----------------------------------------------------------------------
// Widths
// -----------------------------------------------------------------------
`define P9M_PORT_W      16
`define P9M_CS_W        4
`define P9M_FI_W        20

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define P9M_RST_PORT    16'h0000
`define P9M_RST_CS      4'h0
`define P9M_RST_FI      20'h00000

// -----------------------------------------------------------------------
// Pin positions of special functions
// -----------------------------------------------------------------------
`define P9M_PIN_UART    0
`define P9M_PIN_I2C_CLK 1
`define P9M_PIN_TMR_LO  2
`define P9M_PIN_TMR_HI  5
`define P9M_PIN_T2C1    6
`define P9M_PIN_T2C0    7
`define P9M_PIN_CH_LO   8
`define P9M_PIN_CH_HI   13
`define P9M_PIN_T5C1    14
`define P9M_PIN_T5C0    15

// -----------------------------------------------------------------------
// Positions in the peripheral-input vector
// -----------------------------------------------------------------------
`define P9M_FI_KR6      0
`define P9M_FI_KR7      1
`define P9M_FI_URX      2
`define P9M_FI_SDA      3
`define P9M_FI_SCL      4
`define P9M_FI_CAP_LO   5
`define P9M_FI_T2C1     9
`define P9M_FI_T2C0     10
`define P9M_FI_S1DI     11
`define P9M_FI_S1CK     12
`define P9M_FI_S3DI     13
`define P9M_FI_S3CK     14
`define P9M_FI_IRQ4     15
`define P9M_FI_IRQ5     16
`define P9M_FI_IRQ6     17
`define P9M_FI_T5C1     18
`define P9M_FI_T5C0     19

`endif

// >>> logic/p9m_pkg.sv
// Types for the port-9 / chip-select pin-function multiplexer.
// Assumes p9m_cfg.svh is on the include path.
`default_nettype none
`include "p9m_cfg.svh"
package p9m_pkg;

  // Decoded extension/choice pair
  typedef enum logic [1:0] {
    P9M_SEL_00,
    P9M_SEL_01,
    P9M_SEL_10,
    P9M_SEL_11
  } p9m_sel_t;

endpackage
`default_nettype wire

// >>> test/p9m_periph_model.sv
// Model of the peripherals and bus interface feeding the pin multiplexer.
// Assumes the bench reads o_misc in the order listed below.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------
// Peripheral drive: tx, i2c, timers, serial data and clocks
// ----------------------------------------------------------
// o_misc: 0 tx, 1 sda, 2 scl, 3-6 t4c1 t4c0 t3c1 t3c0, 7-8 t2c1 t2c0,
// 9-10 t5c1 t5c0, 11-13 ser1 dout clk oe, 14-16 ser3 dout clk oe
module p9m_periph_model (
  input  wire logic        i_ref_clk,
  output logic [15:0]      o_addr,
  output logic [3:0]       o_cs,
  output logic [16:0]      o_misc
);
  integer seed = 19911;

  initial begin
    o_addr = 16'h0000;
    o_cs   = 4'h0;
    o_misc = 17'h00000;
  end

  // New values every cycle so stale routing shows up
  always @(negedge i_ref_clk) begin
    o_addr = 16'($random(seed));
    o_cs   = 4'($random(seed));
    o_misc = 17'($random(seed));
  end
endmodule
`default_nettype wire

// >>> test/p9m_pin_mux_test.sv
// Self-checking bench for the port-9 and chip-select pin multiplexer.
// Assumes one-cycle registered outputs, all zero while reset is low.
`timescale 1ns/1ps
`default_nettype none

module p9m_pin_mux_test;
  typedef struct packed {
    logic [15:0] out, oe, rd;
    logic [19:0] fi;
    logic [3:0]  cout, coe, crd;
  } p9m_exp_t;

  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [15:0] sel = '0, ext = '0, ch = '0, od = '0, dir = '0, lat = '0;
  logic [15:0] pin = '0, addr, pout, poe, prd;
  logic [3:0]  csel = '0, cdir = '0, clat = '0, cpin = '0, cso;
  logic [3:0]  cout, coe, crd;
  logic [16:0] m;
  logic [19:0] fi;
  p9m_exp_t    exp_q = '0;
  integer      seed = 19910, err_total = 0, n_tests = 0, k, c;

  always #5 i_ref_clk = ~i_ref_clk;

  p9m_periph_model p9m_periph_model_inst (.i_ref_clk(i_ref_clk),
    .o_addr(addr), .o_cs(cso), .o_misc(m));

  p9m_pin_mux p9m_pin_mux_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_function_select_bit(sel), .i_function_extension_bit(ext),
    .i_function_choice_bit(ch), .i_open_drain_bit(od),
    .i_port_direction_bit(dir), .i_port_latch(lat), .i_pin_in(pin),
    .i_cs_function_select_bit(csel), .i_cs_port_direction_bit(cdir),
    .i_cs_port_latch(clat), .i_cs_pin_in(cpin), .i_chip_select_out(cso),
    .i_addr(addr), .i_uart1_transmit(m[0]), .i_i2c2_serial_data_out(m[1]),
    .i_i2c2_serial_clock_out(m[2]), .i_timer4_ch1_out(m[3]),
    .i_timer4_ch0_out(m[4]), .i_timer3_ch1_out(m[5]),
    .i_timer3_ch0_out(m[6]), .i_timer2_ch1_out(m[7]),
    .i_timer2_ch0_out(m[8]), .i_timer5_ch1_out(m[9]),
    .i_timer5_ch0_out(m[10]), .i_serial1_data_out(m[11]),
    .i_serial1_clock_out(m[12]), .i_serial1_clock_oe(m[13]),
    .i_serial3_data_out(m[14]), .i_serial3_clock_out(m[15]),
    .i_serial3_clock_oe(m[16]), .o_pin_out(pout), .o_pin_oe(poe),
    .o_port_read(prd), .o_cs_pin_out(cout), .o_cs_pin_oe(coe),
    .o_cs_port_read(crd), .o_key_return_in_6(fi[0]),
    .o_key_return_in_7(fi[1]), .o_uart1_receive(fi[2]),
    .o_i2c2_serial_data_in(fi[3]), .o_i2c2_serial_clock_in(fi[4]),
    .o_timer4_ch1_capture_in(fi[5]), .o_timer4_ch0_capture_in(fi[6]),
    .o_timer3_ch1_capture_in(fi[7]), .o_timer3_ch0_capture_in(fi[8]),
    .o_timer2_ch1_capture_in(fi[9]), .o_timer2_ch0_capture_in(fi[10]),
    .o_serial1_data_in(fi[11]), .o_serial1_clock_in(fi[12]),
    .o_serial3_data_in(fi[13]), .o_serial3_clock_in(fi[14]),
    .o_ext_irq_in_4(fi[15]), .o_ext_irq_in_5(fi[16]),
    .o_ext_irq_in_6(fi[17]), .o_timer5_ch1_capture_in(fi[18]),
    .o_timer5_ch0_capture_in(fi[19]));

  // ----------------------------------------------------------
  // Expected pin and peripheral values from current inputs
  // ----------------------------------------------------------
  function automatic p9m_exp_t calc();
    p9m_exp_t e;
    logic [1:0] s;
    e = '0;
    e.rd = pin;
    e.crd = cpin;
    for (int i = 0; i < 16; i++) begin
      s = {ext[i], ch[i]};
      if (!sel[i]) begin
        e.out[i] = lat[i];
        e.oe[i] = !dir[i] && !(od[i] && lat[i]);
      end else if ((i >= 8 && i <= 13) ? !ch[i] : s == 2'h0) begin
        e.out[i] = addr[i];
        e.oe[i] = 1'b1;
      end else case (i)
        0: if (s == 2'h1) e.fi[0] = pin[0];
           else if (s == 2'h2) {e.out[0], e.oe[0]} = {m[0], 1'b1};
           else if (od[0]) {e.oe[0], e.fi[3]} = {!m[1], pin[0]};
        1: if (s != 2'h3) {e.fi[1], e.fi[2]} = {pin[1], pin[1] & s[1]};
           else if (od[1]) {e.oe[1], e.fi[4]} = {!m[2], pin[1]};
        2, 3, 4, 5: if (s == 2'h1) e.fi[i+3] = pin[i];
           else if (s == 2'h2) {e.out[i], e.oe[i]} = {m[i+1], 1'b1};
        6, 7: if (s == 2'h2) e.fi[i+3] = pin[i];
           else if (s == 2'h3) {e.out[i], e.oe[i]} = {m[i+1], 1'b1};
           else if (i == 7) e.fi[11] = pin[7];
        8, 11: {e.out[i], e.oe[i]} = {m[i == 8 ? 11 : 14], 1'b1};
        9, 12: begin
          {e.out[i], e.oe[i]} = {m[i+3], m[i+4]};
          e.fi[i == 9 ? 12 : 14] = pin[i];
        end
        10, 13: e.fi[i == 10 ? 13 : 15] = pin[i];
        default: if (s == 2'h1) e.fi[i+2] = pin[i];
           else if (s == 2'h2) e.fi[i+4] = pin[i];
           else {e.out[i], e.oe[i]} = {m[i-5], 1'b1};
      endcase
    end
    for (int j = 0; j < 4; j++) begin
      e.cout[j] = csel[j] ? cso[j] : clat[j];
      e.coe[j] = csel[j] | !cdir[j];
    end
    return e;
  endfunction

  task automatic chk(input logic [19:0] seen, input logic [19:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge i_ref_clk) exp_q <= i_rst_n ? calc() : '0;

  always @(negedge i_ref_clk) begin
    chk(pout & exp_q.oe, exp_q.out & exp_q.oe);
    chk(poe, exp_q.oe);
    chk(fi, exp_q.fi);
    chk({cout & exp_q.coe, coe},
        {exp_q.cout & exp_q.coe, exp_q.coe});
    chk({prd, crd}, {exp_q.rd, exp_q.crd});
  end

  task automatic rnd_io();
    {dir, lat, pin} = 48'({$random(seed), $random(seed)});
    {cdir, clat, cpin} = 12'($random(seed));
  endtask

  // ----------------------------------------------------------
  // Every code on all pins at once, then random traffic
  // ----------------------------------------------------------
  initial begin
    repeat (12) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    for (c = 0; c < 8; c++) begin
      @(negedge i_ref_clk);
      sel = 16'hFFFF;
      csel = 4'hF;
      {ext, ch, od} = {{16{c[1]}}, {16{c[0]}}, {16{c[2]}}};
      rnd_io();
      @(negedge i_ref_clk);
      rnd_io();
    end
    for (k = 0; k < 3000; k++) begin
      @(negedge i_ref_clk);
      i_rst_n = !(k >= 1500 && k < 1503);
      {sel, ext, ch, od} = {$random(seed), $random(seed)};
      csel = 4'($random(seed));
      rnd_io();
    end
    @(negedge i_ref_clk);
    summarize();
  end
endmodule
`default_nettype wire
